/* File: irfc_top.v */
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ps
`include "irfc_defs.vh"

// Behaviour
// - channel one R, P, S dividers, 8-bit read/write, reset 0x6b, 0x2a, 0x1e.
// - channel two R, P, S dividers, 8-bit read/write, reset 0x77, 0x2f, 0x19.
// - size bits 7:6 give capacity 16, 32, 48 or 64 bytes.
// - level events assert once fill reaches B plus one bytes; reset B is 15.
// - continuous receive line a: pattern, signal level, or start detect.
// - buffered receive line a: low, byte strobe, not-empty (standby too), start detect.
// - packet receive line a: payload ready, byte strobe, not-empty (standby too).
// - packet receive code 11: node match if enabled, else start detect.
// - continuous receive line b carries the recovered bit clock, low in standby.
// - buffered receive line b: low, full, signal level, fill level (standby too).
// - packet receive line b: check pass, full (standby), signal level, fill level (standby too).
// - transmit line a: low in continuous, else level or not-empty; rise starts sending.
// - transmit line b: bit clock in continuous, else full or last-bit-sent.
// - read-only bit 1 of routing register shows buffer full.
// - read-only bit 0 of routing register reads low while buffer empty.
// - channel select picks first (0) or second (1) divider set.
// - last-bit-sent reads 0 while shifting out, 1 after the final bit.
// - writing overflow clear empties buffer; in packet mode also rearms packet.
module irfc_top (
    input  wire        clk_i,
    input  wire        rst_b_i,
    input  wire [6:0]  avs_address_i,
    input  wire        avs_read_i,
    input  wire        avs_write_i,
    input  wire [31:0] avs_writedata_i,
    input  wire [3:0]  avs_byteenable_i,
    output wire [31:0] avs_readdata_o,
    output wire        avs_waitrequest_o,
    input  wire        buf_push_i,
    input  wire        buf_pop_i,
    input  wire        standby_i,
    input  wire        pattern_i,
    input  wire        signal_level_event_i,
    input  wire        start_detect_i,
    input  wire        payload_ready_i,
    input  wire        node_match_i,
    input  wire        check_pass_i,
    input  wire        recovered_bit_clock_i,
    input  wire        tx_last_bit_i,
    output wire        host_int_line_a_o,
    output wire        host_int_line_b_o,
    output wire        tx_start_o,
    output wire        packet_rearm_o,
    output wire [7:0]  synth_r_o,
    output wire [7:0]  synth_p_o,
    output wire [7:0]  synth_s_o
);

    // ********************************
    // reset release
    // ********************************
    reg        rst_meta_r;
    reg        rst_sync_r;

    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    wire       rst_b = rst_sync_r;

    // ********************************
    // bus slave
    // ********************************
    // one wait cycle lets read data come from a flop
    reg        ack_r;
    reg [7:0]  rdata_r;
    wire       req = avs_read_i | avs_write_i;
    wire [4:0] idx = avs_address_i[6:2];
    wire       aligned = (avs_address_i[1:0] == 2'b00);
    wire       wr_en = avs_write_i & ack_r & aligned & avs_byteenable_i[0];

    assign avs_waitrequest_o = req & ~ack_r;
    assign avs_readdata_o    = {24'h000000, rdata_r};

    always @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req & ~ack_r;
        end
    end

    // ********************************
    // registers
    // ********************************
    reg  [7:0] c1r_r;
    reg  [7:0] c1p_r;
    reg  [7:0] c1s_r;
    reg  [7:0] c2r_r;
    reg  [7:0] c2p_r;
    reg  [7:0] c2s_r;
    reg  [7:0] size_lvl_r;
    reg  [5:0] route_r;
    reg  [7:0] ctrl_r;
    reg        ovr_clr_r;
    wire [7:0] wd = avs_writedata_i[7:0];

    always @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
            c1r_r      <= `IRFC_RST_C1R;
            c1p_r      <= `IRFC_RST_C1P;
            c1s_r      <= `IRFC_RST_C1S;
            c2r_r      <= `IRFC_RST_C2R;
            c2p_r      <= `IRFC_RST_C2P;
            c2s_r      <= `IRFC_RST_C2S;
            size_lvl_r <= `IRFC_RST_SIZE_LVL;
            route_r    <= `IRFC_RST_IRQ_ROUTE;
            ctrl_r     <= `IRFC_RST_CTRL;
            ovr_clr_r  <= 1'b0;
        end else begin
            ovr_clr_r <= 1'b0;
            if (wr_en) begin
                case (idx)
                    `IRFC_IDX_C1R:       c1r_r      <= wd;
                    `IRFC_IDX_C1P:       c1p_r      <= wd;
                    `IRFC_IDX_C1S:       c1s_r      <= wd;
                    `IRFC_IDX_C2R:       c2r_r      <= wd;
                    `IRFC_IDX_C2P:       c2p_r      <= wd;
                    `IRFC_IDX_C2S:       c2s_r      <= wd;
                    `IRFC_IDX_SIZE_LVL:  size_lvl_r <= wd;
                    `IRFC_IDX_IRQ_ROUTE: route_r    <= wd[7:2];
                    `IRFC_IDX_CTRL: begin
                        // overflow clear is a strobe, never stored
                        ctrl_r    <= {wd[7:4], 1'b0, wd[2:0]};
                        ovr_clr_r <= wd[`IRFC_OVR_BIT];
                    end
                    default:             ctrl_r     <= ctrl_r;
                endcase
            end
        end
    end

    wire [1:0] data_mode = ctrl_r[`IRFC_MODE_HI:`IRFC_MODE_LO];
    wire       tx_dir    = ctrl_r[`IRFC_TXDIR_BIT];
    wire       node_en   = ctrl_r[`IRFC_NODE_EN_BIT];
    wire       chan_sel  = ctrl_r[`IRFC_CHSEL_BIT];
    wire       mode_cont = (data_mode == `IRFC_MODE_CONT);
    wire       mode_buf  = (data_mode == `IRFC_MODE_BUF);
    wire       mode_pkt  = data_mode[1];

    // ********************************
    // synthesizer divider select
    // ********************************
    reg  [7:0] syn_r_r;
    reg  [7:0] syn_p_r;
    reg  [7:0] syn_s_r;

    always @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
            syn_r_r <= `IRFC_RST_C1R;
            syn_p_r <= `IRFC_RST_C1P;
            syn_s_r <= `IRFC_RST_C1S;
        end else begin
            syn_r_r <= chan_sel ? c2r_r : c1r_r;
            syn_p_r <= chan_sel ? c2p_r : c1p_r;
            syn_s_r <= chan_sel ? c2s_r : c1s_r;
        end
    end

    assign synth_r_o = syn_r_r;
    assign synth_p_o = syn_p_r;
    assign synth_s_o = syn_s_r;

    // ********************************
    // buffer fill tracking
    // ********************************
    reg  [6:0] fill_r;
    reg  [6:0] fill_nxt;
    wire [6:0] cap;
    wire [6:0] lvl_bytes;
    wire       buf_full;
    wire       buf_nempty;
    wire       fill_event;

    assign cap = {3'b000, size_lvl_r[`IRFC_SIZE_HI:`IRFC_SIZE_LO], 2'b00} * 7'h04
               + `IRFC_SIZE_UNIT;
    assign lvl_bytes  = {1'b0, size_lvl_r[`IRFC_LVL_HI:`IRFC_LVL_LO]} + 7'h01;
    assign buf_full   = (fill_r >= cap);
    assign buf_nempty = (fill_r != 7'h00);
    assign fill_event = (fill_r >= lvl_bytes);

    always @* begin
        fill_nxt = fill_r;
        if (ovr_clr_r) begin
            // a byte landing with the clear is kept
            fill_nxt = buf_push_i ? 7'h01 : 7'h00;
        end else if (buf_push_i & ~buf_full & ~(buf_pop_i & buf_nempty)) begin
            fill_nxt = fill_r + 7'h01;
        end else if (buf_pop_i & buf_nempty & ~buf_push_i) begin
            fill_nxt = fill_r - 7'h01;
        end
    end

    always @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
            fill_r <= 7'h00;
        end else begin
            fill_r <= fill_nxt;
        end
    end

    reg        rearm_r;

    always @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
            rearm_r <= 1'b0;
        end else begin
            rearm_r <= ovr_clr_r & mode_pkt;
        end
    end

    assign packet_rearm_o = rearm_r;

    // ********************************
    // interrupt line routing
    // ********************************
    wire [1:0] rxa_sel = route_r[`IRFC_RXA_HI-2:`IRFC_RXA_LO-2];
    wire [1:0] rxb_sel = route_r[`IRFC_RXB_HI-2:`IRFC_RXB_LO-2];
    wire       txa_sel = route_r[`IRFC_TXA_BIT-2];
    wire       txb_sel = route_r[`IRFC_TXB_BIT-2];
    reg        line_a_nxt;
    reg        line_b_nxt;
    reg        sb_a_ok;
    reg        sb_b_ok;

    // recomputed every cycle from live mode, direction and fields
    always @* begin
        line_a_nxt = 1'b0;
        line_b_nxt = 1'b0;
        sb_a_ok    = 1'b0;
        sb_b_ok    = 1'b0;
        if (tx_dir) begin
            if (mode_cont) begin
                line_a_nxt = 1'b0;
                line_b_nxt = recovered_bit_clock_i;
            end else begin
                line_a_nxt = txa_sel ? buf_nempty : fill_event;
                line_b_nxt = txb_sel ? tx_last_bit_i : buf_full;
            end
        end else if (mode_cont) begin
            case (rxa_sel)
                2'b00: begin
                    line_a_nxt = pattern_i;
                end
                2'b01: begin
                    line_a_nxt = signal_level_event_i;
                end
                default: begin
                    line_a_nxt = start_detect_i;
                end
            endcase
            line_b_nxt = recovered_bit_clock_i;
        end else if (mode_buf) begin
            case (rxa_sel)
                2'b00: begin
                    line_a_nxt = 1'b0;
                end
                2'b01: begin
                    line_a_nxt = buf_push_i;
                end
                2'b10: begin
                    line_a_nxt = buf_nempty;
                    sb_a_ok    = 1'b1;
                end
                default: begin
                    line_a_nxt = start_detect_i;
                end
            endcase
            case (rxb_sel)
                2'b00: begin
                    line_b_nxt = 1'b0;
                end
                2'b01: begin
                    line_b_nxt = buf_full;
                end
                2'b10: begin
                    line_b_nxt = signal_level_event_i;
                end
                default: begin
                    line_b_nxt = fill_event;
                    sb_b_ok    = 1'b1;
                end
            endcase
        end else begin
            case (rxa_sel)
                2'b00: begin
                    line_a_nxt = payload_ready_i;
                end
                2'b01: begin
                    line_a_nxt = buf_push_i;
                end
                2'b10: begin
                    line_a_nxt = buf_nempty;
                    sb_a_ok    = 1'b1;
                end
                default: begin
                    line_a_nxt = node_en ? node_match_i : start_detect_i;
                end
            endcase
            case (rxb_sel)
                2'b00: begin
                    line_b_nxt = check_pass_i;
                end
                2'b01: begin
                    line_b_nxt = buf_full;
                    sb_b_ok    = 1'b1;
                end
                2'b10: begin
                    line_b_nxt = signal_level_event_i;
                end
                default: begin
                    line_b_nxt = fill_event;
                    sb_b_ok    = 1'b1;
                end
            endcase
        end
        // in standby only the flagged receive sources stay live
        if (standby_i & ~tx_dir & ~sb_a_ok) begin
            line_a_nxt = 1'b0;
        end
        if (standby_i & ~tx_dir & ~sb_b_ok) begin
            line_b_nxt = 1'b0;
        end
    end

    reg        line_a_r;
    reg        line_b_r;
    reg        tx_start_r;

    always @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
            line_a_r   <= 1'b0;
            line_b_r   <= 1'b0;
            tx_start_r <= 1'b0;
        end else begin
            line_a_r   <= line_a_nxt;
            line_b_r   <= line_b_nxt;
            // sending kicks off on the rising edge of line a
            tx_start_r <= tx_dir & ~mode_cont & line_a_nxt & ~line_a_r;
        end
    end

    assign host_int_line_a_o = line_a_r;
    assign host_int_line_b_o = line_b_r;
    assign tx_start_o        = tx_start_r;

    // ********************************
    // read path
    // ********************************
    reg  [7:0] rd_mux;

    always @* begin
        rd_mux = 8'h00;
        if (aligned) begin
            case (idx)
                `IRFC_IDX_C1R:       rd_mux = c1r_r;
                `IRFC_IDX_C1P:       rd_mux = c1p_r;
                `IRFC_IDX_C1S:       rd_mux = c1s_r;
                `IRFC_IDX_C2R:       rd_mux = c2r_r;
                `IRFC_IDX_C2P:       rd_mux = c2p_r;
                `IRFC_IDX_C2S:       rd_mux = c2s_r;
                `IRFC_IDX_SIZE_LVL:  rd_mux = size_lvl_r;
                `IRFC_IDX_IRQ_ROUTE: rd_mux = {route_r, buf_full, buf_nempty};
                `IRFC_IDX_CTRL:      rd_mux = ctrl_r;
                `IRFC_IDX_STATUS:    rd_mux = {tx_last_bit_i, fill_r};
                default:             rd_mux = 8'h00;
            endcase
        end
    end

    always @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
            rdata_r <= 8'h00;
        end else if (avs_read_i & ~ack_r) begin
            rdata_r <= rd_mux;
        end
    end

endmodule // irfc_top

/* File: irfc_defs.vh */
`ifndef IRFC_DEFS_VH
`define IRFC_DEFS_VH

// ********************************
// register indices, byte address = 4 * index
// ********************************
`define IRFC_IDX_W         5
`define IRFC_IDX_C1R       5'h06
`define IRFC_IDX_C1P       5'h07
`define IRFC_IDX_C1S       5'h08
`define IRFC_IDX_C2R       5'h09
`define IRFC_IDX_C2P       5'h0a
`define IRFC_IDX_C2S       5'h0b
`define IRFC_IDX_SIZE_LVL  5'h0c
`define IRFC_IDX_IRQ_ROUTE 5'h0d
`define IRFC_IDX_CTRL      5'h10
`define IRFC_IDX_STATUS    5'h11

// ********************************
// reset values
// ********************************
`define IRFC_RST_C1R       8'h6b
`define IRFC_RST_C1P       8'h2a
`define IRFC_RST_C1S       8'h1e
`define IRFC_RST_C2R       8'h77
`define IRFC_RST_C2P       8'h2f
`define IRFC_RST_C2S       8'h19
`define IRFC_RST_SIZE_LVL  8'h0f
`define IRFC_RST_IRQ_ROUTE 6'h00
`define IRFC_RST_CTRL      8'h00

// ********************************
// field positions
// ********************************
`define IRFC_SIZE_HI       7
`define IRFC_SIZE_LO       6
`define IRFC_LVL_HI        5
`define IRFC_LVL_LO        0
`define IRFC_RXA_HI        7
`define IRFC_RXA_LO        6
`define IRFC_RXB_HI        5
`define IRFC_RXB_LO        4
`define IRFC_TXA_BIT       3
`define IRFC_TXB_BIT       2
`define IRFC_FULL_BIT      1
`define IRFC_NEMPTY_BIT    0
`define IRFC_MODE_HI       7
`define IRFC_MODE_LO       6
`define IRFC_TXDIR_BIT     5
`define IRFC_NODE_EN_BIT   4
`define IRFC_OVR_BIT       3
`define IRFC_CHSEL_BIT     0
`define IRFC_TXLAST_BIT    7

// ********************************
// data modes and buffer sizing
// ********************************
`define IRFC_MODE_CONT     2'b00
`define IRFC_MODE_BUF      2'b01
`define IRFC_CNT_W         7
`define IRFC_SIZE_UNIT     7'h10

`endif

/* File: irfc_asserts.sv */
`timescale 1ns/1ps
// ********
// checker on the top ports
// ********
module irfc_asserts (
    input wire        clk_i,
    input wire        rst_b_i,
    input wire [6:0]  avs_address_i,
    input wire        avs_read_i,
    input wire        avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [3:0]  avs_byteenable_i,
    input wire        avs_waitrequest_o,
    input wire        standby_i,
    input wire        pattern_i,
    input wire        signal_level_event_i,
    input wire        start_detect_i,
    input wire        node_match_i,
    input wire        recovered_bit_clock_i,
    input wire        tx_last_bit_i,
    input wire        host_int_line_a_o,
    input wire        host_int_line_b_o,
    input wire        tx_start_o,
    input wire        packet_rearm_o,
    input wire [7:0]  synth_p_o
);
    reg  [3:0] ok_r;
    reg  [7:0] ctl_r;
    reg  [7:0] rte_r;
    wire       acc = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
    wire       ovr = acc && avs_address_i == 7'h40 && avs_writedata_i[3];
    wire       rx  = !ctl_r[5] && !standby_i;

    // shadow of mode and routing; lines are predicted from ports alone
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ok_r  <= 4'h0;
            ctl_r <= 8'h00;
            rte_r <= 8'h00;
        end else begin
            ok_r <= {ok_r[2:0], 1'b1};
            if (acc && avs_address_i == 7'h40)
                ctl_r <= avs_writedata_i[7:0];
            if (acc && avs_address_i == 7'h34)
                rte_r <= avs_writedata_i[7:0];
        end
    end

    // wait for the synchronised reset to settle before judging
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!ok_r[3]);

    wait_one_a: assert property ($rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
        else $error("bus answer not after one wait cycle");
    start_pulse_a: assert property (tx_start_o |-> host_int_line_a_o ##1 !tx_start_o)
        else $error("send start not a single pulse with line a");
    cont_txa_a: assert property ($past(ctl_r[7:5] == 3'h1) |-> !host_int_line_a_o)
        else $error("line a not low in continuous send");
    rearm_a: assert property (packet_rearm_o |-> $past(ovr, 1) || $past(ovr, 2))
        else $error("rearm without overflow clear");
    synth_a: assert property ($changed(synth_p_o) |-> $past(acc, 2))
        else $error("divider output moved without a write");
    cont_rxa_a: assert property ($past(rx && ctl_r[7:6] == 2'h0) |-> host_int_line_a_o ==
        $past(rte_r[7:6] == 2'h0 ? pattern_i : rte_r[7:6] == 2'h1 ? signal_level_event_i : start_detect_i))
        else $error("line a wrong in continuous receive");
    cont_rxb_a: assert property ($past(rx && ctl_r[7:6] == 2'h0) |->
        host_int_line_b_o == $past(recovered_bit_clock_i))
        else $error("line b not the bit clock");
    pkt_match_a: assert property ($past(rx && ctl_r[7] && rte_r[7:6] == 2'h3) |->
        host_int_line_a_o == $past(ctl_r[4] ? node_match_i : start_detect_i))
        else $error("line a wrong for packet code 3");
    tx_b_a: assert property ($past(ctl_r[5] && (ctl_r[7:6] == 2'h0 || rte_r[2])) |->
        host_int_line_b_o == $past(ctl_r[7:6] == 2'h0 ? recovered_bit_clock_i : tx_last_bit_i))
        else $error("line b wrong in send");
endmodule // irfc_asserts

bind irfc_top irfc_asserts u_irfc_asserts (.*);

/* File: irfc_host.sv */
`timescale 1ns/1ps
// ********
// host model: register master
// ********
module irfc_host (
    input  wire        clk_i,
    input  wire        waitreq_i,
    input  wire [31:0] rdata_i,
    output reg  [6:0]  addr_o,
    output reg         rd_o,
    output reg         wr_o,
    output reg  [31:0] wdata_o,
    output reg  [3:0]  be_o
);
    initial begin
        addr_o  = 7'h00;
        rd_o    = 1'b0;
        wr_o    = 1'b0;
        wdata_o = 32'h0;
        be_o    = 4'h0;
    end

    // holds the request until an edge sees waitrequest low
    task hold;
        begin
            @(posedge clk_i);
            while (waitreq_i)
                @(posedge clk_i);
        end
    endtask

    // each access ends one edge after release, so strobes never toggle twice in a step
    task wr(input [4:0] idx, input [7:0] v, input [3:0] be);
        begin
            addr_o  <= {idx, 2'h0};
            wdata_o <= {24'h0, v};
            be_o    <= be;
            wr_o    <= 1'b1;
            hold;
            wr_o    <= 1'b0;
            @(posedge clk_i);
        end
    endtask

    task rd(input [4:0] idx, output [31:0] v);
        begin
            addr_o <= {idx, 2'h0};
            rd_o   <= 1'b1;
            hold;
            v = rdata_i;
            rd_o   <= 1'b0;
            @(posedge clk_i);
        end
    endtask
endmodule // irfc_host

/* File: test_irq_routing_fifo_config.sv */
`timescale 1ns/1ps
module test_irq_routing_fifo_config;
    reg         clk_i = 1'b0;
    reg         rst_b_i = 1'b0;
    reg  [7:0]  src = 8'h0;
    reg         sb = 1'b0;
    reg         push = 1'b0;
    reg         pop = 1'b0;
    wire [6:0]  adr;
    wire        rd, wr, wq, la, lb, tx_start, rearm;
    wire [3:0]  be;
    wire [31:0] wd, rdat;
    wire [7:0]  syn_r, syn_p, syn_s;
    reg  [7:0]  regs [0:31];
    reg  [63:0] rst_v = 64'h000f192f771e2a6b;
    reg  [31:0] seed = 32'hbe1940a3;
    reg  [31:0] d;
    integer     n_mismatch = 0, n_tests = 0, cnt = 0, n_start = 0, n_rearm = 0, i, k;

    always #50 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        n_start <= n_start + tx_start;
        n_rearm <= n_rearm + rearm;
    end

    irfc_top u_irfc_top (.clk_i(clk_i), .rst_b_i(rst_b_i), .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wq), .buf_push_i(push), .buf_pop_i(pop), .standby_i(sb), .pattern_i(src[0]),
        .signal_level_event_i(src[1]), .start_detect_i(src[2]), .payload_ready_i(src[3]),
        .node_match_i(src[4]), .check_pass_i(src[5]), .recovered_bit_clock_i(src[6]),
        .tx_last_bit_i(src[7]), .host_int_line_a_o(la), .host_int_line_b_o(lb), .tx_start_o(tx_start),
        .packet_rearm_o(rearm), .synth_r_o(syn_r), .synth_p_o(syn_p), .synth_s_o(syn_s));
    irfc_host host (.clk_i(clk_i), .waitreq_i(wq), .rdata_i(rdat), .addr_o(adr), .rd_o(rd), .wr_o(wr),
        .wdata_o(wd), .be_o(be));

    // ********
    // reference model
    // ********
    function [31:0] xs();
        begin
            seed = seed ^ (seed << 13);
            seed = seed ^ (seed >> 17);
            seed = seed ^ (seed << 5);
            xs = seed;
        end
    endfunction

    function full();
        full = cnt >= 16 * (regs[12][7:6] + 1);
    endfunction

    function [7:0] exp_rd(input [4:0] x);
        exp_rd = (x == 5'h0d) ? {regs[13][7:2], full(), cnt != 0} : (x == 5'h11) ? {src[7], cnt[6:0]} : regs[x];
    endfunction

    function [1:0] exp_lines();
        reg [7:0] c, r;
        reg       n, l, a, b;
        begin
            c = regs[16];
            r = regs[13];
            n = cnt != 0;
            l = cnt >= regs[12][5:0] + 1;
            if (c[5]) begin
                a = (c[7:6] == 2'h0) ? 1'b0 : r[3] ? n : l;
                b = (c[7:6] == 2'h0) ? src[6] : r[2] ? src[7] : full();
            end else if (c[7:6] == 2'h0) begin
                a = !sb & ((r[7:6] == 2'h0) ? src[0] : (r[7:6] == 2'h1) ? src[1] : src[2]);
                b = !sb & src[6];
            end else begin
                case (r[7:6])
                    2'h0: a = c[7] & src[3];
                    2'h1: a = push;
                    2'h2: a = n;
                    default: a = (c[7] & c[4]) ? src[4] : src[2];
                endcase
                case (r[5:4])
                    2'h0: b = c[7] & src[5];
                    2'h1: b = full();
                    2'h2: b = src[1];
                    default: b = l;
                endcase
                // standby keeps only the buffer flags alive
                if (sb) begin
                    a = a & (r[7:6] == 2'h2);
                    b = b & (r[5:4] == 2'h3 || (r[5:4] == 2'h1 && c[7]));
                end
            end
            exp_lines = {a, b};
        end
    endfunction

    // ********
    // compare and drive tasks
    // ********
    task tally(input bad, input [31:0] g, input [31:0] e);
        begin
            n_tests = n_tests + 1;
            if (bad) begin
                n_mismatch = n_mismatch + 1;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
            end
        end
    endtask

    task cmp_rd(input [31:0] g, input [31:0] e);
        tally(g !== e, g, e);
    endtask

    task cmp_ln(input [31:0] g, input [31:0] e);
        tally(g !== e, g, e);
    endtask

    task wreg(input [4:0] x, input [7:0] v, input [3:0] e);
        begin
            host.wr(x, v, e);
            if (e[0] && ((x >= 6 && x <= 13) || x == 16)) begin
                regs[x] = (x == 13) ? {v[7:2], 2'h0} : (x == 16) ? v & 8'hf7 : v;
                if (x == 16 && v[3])
                    cnt = 0;
            end
        end
    endtask

    task chk_lines;
        begin
            repeat (2) @(posedge clk_i);
            #1 cmp_ln({la, lb}, exp_lines());
            @(posedge clk_i);
        end
    endtask

    task pulse(input p);
        begin
            push <= p;
            pop  <= !p;
            @(posedge clk_i);
            push <= 1'b0;
            pop  <= 1'b0;
            if (p && !full())
                cnt = cnt + 1;
            if (!p && cnt > 0)
                cnt = cnt - 1;
            chk_lines;
        end
    endtask

    task give_verdict;
        begin
            $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
            if (n_mismatch == 0 && n_tests > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask

    // ********
    // scenarios
    // ********
    initial begin
        #3000000;
        n_mismatch = n_mismatch + 1;
        give_verdict;
    end

    initial begin
        for (i = 0; i < 32; i = i + 1)
            regs[i] = (i >= 6 && i <= 13) ? rst_v[(i - 6) * 8 +: 8] : 8'h00;
        repeat (5) @(posedge clk_i);
        rst_b_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        for (i = 0; i < 32; i = i + 1) begin
            host.rd(i, d);
            cmp_rd(d, exp_rd(i));
        end
        for (i = 0; i < 24; i = i + 1) begin
            d = xs();
            k = d[4:0];
            wreg(d[4:0], d[15:8], d[19:16]);
            host.rd(k, d);
            cmp_rd(d, exp_rd(k));
        end
        for (i = 0; i < 2; i = i + 1) begin
            wreg(16, i, 4'hf);
            repeat (2) @(posedge clk_i);
            d = i ? {regs[9], regs[10], regs[11]} : {regs[6], regs[7], regs[8]};
            #1 cmp_ln({syn_r, syn_p, syn_s}, d);
            @(posedge clk_i);
        end
        // sizing and routing go in before any transfer
        for (i = 0; i < 4; i = i + 1) begin
            d = xs();
            wreg(13, i[0] ? 8'hb0 : 8'h90, 4'hf);
            wreg(12, {i[1:0], d[5:0]}, 4'hf);
            wreg(16, i[1] ? 8'h88 : 8'h48, 4'hf);
            for (k = 0; k <= 16 * (i + 1); k = k + 1)
                pulse(1'b1);
            host.rd(13, d);
            cmp_rd(d, exp_rd(13));
            host.rd(17, d);
            cmp_rd(d, exp_rd(17));
            while (cnt > 0)
                pulse(1'b0);
        end
        wreg(16, 8'h40, 4'hf);
        repeat (3) pulse(1'b1);
        k = n_rearm;
        wreg(16, 8'h48, 4'hf);
        host.rd(17, d);
        cmp_rd(d, exp_rd(17));
        wreg(16, 8'h80, 4'hf);
        wreg(16, 8'h88, 4'hf);
        repeat (2) @(posedge clk_i);
        cmp_ln(n_rearm - k, 1);
        wreg(13, 8'h00, 4'hf);
        wreg(12, 8'h03, 4'hf);
        wreg(16, 8'h60, 4'hf);
        k = n_start;
        repeat (4) pulse(1'b1);
        cmp_ln(n_start - k, 1);
        for (i = 0; i < 60; i = i + 1) begin
            d = xs();
            wreg(16, d[7:0] & 8'hf7, 4'hf);
            wreg(13, d[15:8], 4'hf);
            wreg(12, d[23:16], 4'hf);
            d = xs();
            src <= d[7:0];
            sb  <= d[8] & d[9];
            chk_lines;
        end
        give_verdict;
    end
endmodule // test_irq_routing_fifo_config
